// file: sio_blink_gen.sv
// Blink rate divider and burst toggle shared by all serial pins
`default_nettype none

module sio_blink_gen #(
    parameter int unsigned HALF_CYC = 3125000
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    // Control
    input  wire logic       clear,
    input  wire logic       burst_done,
    // Patterns
    output logic      [3:0] wave,
    output logic            burst_tog
);
    localparam int unsigned PW = (HALF_CYC < 2) ? 1 : $clog2(HALF_CYC);

    logic [PW-1:0] pre;

    // Refuse a prescaler that cannot divide
    if (HALF_CYC < 2) begin : g_chk
        $error("sio_blink_gen: HALF_CYC must be at least 2");
    end

    // Prescaler: one tick per half period of the fastest rate
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pre <= '0;
        end else if (clear || pre == PW'(HALF_CYC - 1)) begin
            pre <= '0;
        end else begin
            pre <= pre + 1'b1;
        end
    end

    // Binary divider: bit k is 20 Hz halved k times
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wave <= 4'h0;
        end else if (clear) begin
            wave <= 4'h0;
        end else if (pre == PW'(HALF_CYC - 1)) begin
            wave <= wave + 4'h1;
        end
    end

    // Burst toggle flips once per finished burst
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            burst_tog <= 1'b0;
        end else if (clear) begin
            burst_tog <= 1'b0;
        end else if (burst_done) begin
            burst_tog <= ~burst_tog;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_blink_clear: assert property (clear |=> (wave == 4'h0 && pre == '0 && !burst_tog))
        else $error("blink counter not cleared");
    a_burst_flip: assert property ((burst_done && !clear) |=> burst_tog != $past(burst_tog))
        else $error("burst toggle did not flip");
    c_burst_flip: cover property ((burst_done && !burst_tog) ##1 burst_tog);
endmodule

`default_nettype wire

// file: sio_act_stretch.sv
// Activity envelope stretcher for one port module
`default_nettype none

module sio_act_stretch #(
    parameter int unsigned HOLD_CYC = 12500000
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // Activity in, envelope out
    input  wire logic activity,
    output logic      env
);
    localparam int unsigned CW = $clog2(HOLD_CYC + 1);

    logic [CW-1:0] cnt;

    // Refuse a hold too short to count
    if (HOLD_CYC < 2) begin : g_chk
        $error("sio_act_stretch: HOLD_CYC must be at least 2");
    end

    // Each pulse reloads the full hold, so later packets extend it
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= '0;
        end else if (activity) begin
            cnt <= CW'(HOLD_CYC - 1);
        end else if (cnt != '0) begin
            cnt <= cnt - 1'b1;
        end
    end

    // Envelope stays high for HOLD_CYC cycles after the last pulse
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            env <= 1'b0;
        end else begin
            env <= activity || cnt != '0;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_env_load: assert property (activity |=> (env && cnt == CW'(HOLD_CYC - 1)))
        else $error("envelope not reloaded by activity");
    a_env_drop: assert property ($fell(env) |-> ($past(cnt) == '0 && !$past(activity)))
        else $error("envelope fell before hold ended");
    c_env_end: cover property (env ##1 !env);
endmodule

`default_nettype wire

// file: sio_led_irq.sv
// Serial pin output modes, interrupt and loss-of-signal logic, with its package
`default_nettype none

// Overview of operation
// - Each pin picks static, blink or activity
// - Static mode drives fixed 0 or 1
// - Two blink patterns; pin selects one
// - Pattern zero: 20, 10, 5, 2.5 Hz
// - Pattern one setting 3 toggles per burst
// - Software clears blink counter for alignment
// - Port n activity comes from module n
// - Envelope gates blinking; pin is 0 when deasserted, 1 in the inverted modes
// - Pulse holds envelope 100 ms, extendable
// - Output source setting selects activity polarity
// - Interrupts are level sensitive on inputs
// - Port enable and position enable both needed
// - Polarity setting per serial pin
// - One interrupt output when any active
// - Sticky status per pin, write-one clears
// - Interrupt stays high until status cleared or its enable removed
// - Pin bit 0 feeds port LOS input
// - GPIO-sourced LOS ignores serial value
// - LOS uses the interrupt polarity setting
// - 128 pins as 32 ports of four
// - Bursts end with load; toggle counts them
package sio_pkg;
    // Geometry
    localparam int unsigned NUM_PORTS = 32;
    localparam int unsigned PIN_PER_PORT = 4;
    localparam int unsigned NUM_PINS = NUM_PORTS * PIN_PER_PORT;
    // Timing
    localparam longint unsigned CLK_HZ = 125000000;
    localparam longint unsigned FAST_BLINK_HZ = 20;
    localparam longint unsigned ENV_HOLD_MS = 100;
    localparam int unsigned BLINK_HALF_CYC = int'(CLK_HZ / (2 * FAST_BLINK_HZ));
    localparam int unsigned ENV_HOLD_CYC = int'(CLK_HZ * ENV_HOLD_MS / 1000);
    // Register offsets
    localparam logic [8:0] ADDR_GEN = 9'h000;
    localparam logic [8:0] ADDR_PIE = 9'h004;
    localparam logic [8:0] ADDR_POL = 9'h010;
    localparam logic [8:0] ADDR_STS = 9'h020;
    localparam logic [8:0] ADDR_IN = 9'h030;
    localparam logic [8:0] ADDR_OCFG = 9'h100;
    // General config fields
    localparam int unsigned GEN_BP0_LSB = 0;
    localparam int unsigned GEN_BP1_LSB = 2;
    localparam int unsigned GEN_CLR_BIT = 4;
    localparam int unsigned GEN_POS_LSB = 8;
    // Reset values
    localparam logic [1:0] BP_RST = 2'h0;
    localparam logic [3:0] POS_RST = 4'h0;
    localparam logic [31:0] PIE_RST = 32'h0000_0000;
    localparam logic [11:0] OCFG_RST = 12'h000;
    // Pattern one setting that selects burst toggle
    localparam logic [1:0] BP_BURST = 2'h3;
    // Per-pin output source codes
    localparam logic [2:0] SRC_STATIC0 = 3'h0;
    localparam logic [2:0] SRC_STATIC1 = 3'h1;
    localparam logic [2:0] SRC_BLINK0 = 3'h2;
    localparam logic [2:0] SRC_BLINK1 = 3'h3;
    localparam logic [2:0] SRC_ACT0 = 3'h4;
    localparam logic [2:0] SRC_ACT1 = 3'h5;
    localparam logic [2:0] SRC_ACT0_INV = 3'h6;
    localparam logic [2:0] SRC_ACT1_INV = 3'h7;
endpackage

module sio_led_irq #(
    parameter int unsigned BLINK_HALF_CYC = sio_pkg::BLINK_HALF_CYC,
    parameter int unsigned ENV_HOLD_CYC   = sio_pkg::ENV_HOLD_CYC
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    // Register port
    input  wire logic [8:0]   reg_addr,
    input  wire logic [31:0]  reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output logic      [31:0]  reg_rdata,
    // Shift engine side
    input  wire logic [127:0] pin_in,
    input  wire logic         pin_in_valid,
    input  wire logic         burst_done,
    output logic      [127:0] pin_out,
    // Port modules
    input  wire logic [31:0]  port_activity,
    input  wire logic [31:0]  gpio_los_sel,
    output logic      [31:0]  los_out,
    // Interrupt controller
    output logic              irq
);
    logic [1:0]   blink_pattern_zero;
    logic [1:0]   blink_pattern_one;
    logic [3:0]   position_irq_enable;
    logic         blink_counter_clear;
    logic [31:0]  port_interrupt_enable;
    logic [127:0] pin_polarity;
    logic [127:0] sticky_irq_status;
    logic [127:0] input_data;
    logic [11:0]  serial_output_config [0:31];
    logic [127:0] pin_active;
    logic [127:0] irq_mask;
    logic [127:0] next_sticky;
    logic [127:0] next_pin_out;
    logic [31:0]  next_rdata;
    logic [31:0]  act_env;
    logic [3:0]   blink_wave;
    logic         burst_tog;
    logic         wave0;
    logic         wave1;
    logic         aligned;
    logic         wr_gen;
    logic         wr_pie;
    logic         wr_pol;
    logic         wr_sts;
    logic         wr_ocfg;

    // Refuse geometry the register map cannot hold
    if (sio_pkg::NUM_PINS != 128) begin : g_chk
        $error("sio_led_irq: register map serves exactly 128 pins");
    end

    // Write decode; unaligned or unmapped writes are dropped
    assign aligned = reg_addr[1:0] == 2'h0;
    assign wr_gen  = reg_wr && reg_addr == sio_pkg::ADDR_GEN;
    assign wr_pie  = reg_wr && reg_addr == sio_pkg::ADDR_PIE;
    assign wr_pol  = reg_wr && aligned && reg_addr[8:4] == sio_pkg::ADDR_POL[8:4];
    assign wr_sts  = reg_wr && aligned && reg_addr[8:4] == sio_pkg::ADDR_STS[8:4];
    assign wr_ocfg = reg_wr && aligned && reg_addr[8:7] == sio_pkg::ADDR_OCFG[8:7];

    // General configuration; the clear bit is a one-cycle pulse
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            blink_pattern_zero  <= sio_pkg::BP_RST;
            blink_pattern_one   <= sio_pkg::BP_RST;
            position_irq_enable <= sio_pkg::POS_RST;
            blink_counter_clear <= 1'b0;
        end else begin
            blink_counter_clear <= wr_gen && reg_wdata[sio_pkg::GEN_CLR_BIT];
            if (wr_gen) begin
                blink_pattern_zero  <= reg_wdata[sio_pkg::GEN_BP0_LSB +: 2];
                blink_pattern_one   <= reg_wdata[sio_pkg::GEN_BP1_LSB +: 2];
                position_irq_enable <= reg_wdata[sio_pkg::GEN_POS_LSB +: 4];
            end
        end
    end

    // Port interrupt enables
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            port_interrupt_enable <= sio_pkg::PIE_RST;
        end else if (wr_pie) begin
            port_interrupt_enable <= reg_wdata;
        end
    end

    // Per-pin polarity, four words
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pin_polarity <= '0;
        end else if (wr_pol) begin
            pin_polarity[{reg_addr[3:2], 5'h00} +: 32] <= reg_wdata;
        end
    end

    // Per-port output source words
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int p = 0; p < 32; p++) begin
                serial_output_config[p] <= sio_pkg::OCFG_RST;
            end
        end else if (wr_ocfg) begin
            serial_output_config[reg_addr[6:2]] <= reg_wdata[11:0];
        end
    end

    // Latest sampled inputs from the shift engine
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            input_data <= '0;
        end else if (pin_in_valid) begin
            input_data <= pin_in;
        end
    end

    // Polarity correction and the two-level enable mask
    assign pin_active = input_data ^ pin_polarity;
    for (genvar i = 0; i < 128; i++) begin : g_mask
        assign irq_mask[i] = port_interrupt_enable[i / 4] & position_irq_enable[i % 4];
    end

    // Sticky status: a pending level wins over a clear in the same cycle
    always_comb begin
        next_sticky = sticky_irq_status;
        if (wr_sts) begin
            next_sticky[{reg_addr[3:2], 5'h00} +: 32] =
                sticky_irq_status[{reg_addr[3:2], 5'h00} +: 32] & ~reg_wdata;
        end
        next_sticky = next_sticky | pin_active;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sticky_irq_status <= '0;
        end else begin
            sticky_irq_status <= next_sticky;
        end
    end

    // Single interrupt line, held while any enabled status bit remains
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(sticky_irq_status & irq_mask);
        end
    end

    // Bit 0 of each port feeds port module LOS unless GPIO supplies it
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            los_out <= '0;
        end else begin
            for (int p = 0; p < 32; p++) begin
                los_out[p] <= !gpio_los_sel[p] && pin_active[4 * p];
            end
        end
    end

    // Shared blink patterns
    sio_blink_gen #(
        .HALF_CYC (BLINK_HALF_CYC)
    ) u_blink (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .clear      (blink_counter_clear),
        .burst_done (burst_done),
        .wave       (blink_wave),
        .burst_tog  (burst_tog)
    );

    // One envelope per port, port n fed by port module n
    for (genvar p = 0; p < 32; p++) begin : g_env
        sio_act_stretch #(
            .HOLD_CYC (ENV_HOLD_CYC)
        ) u_env (
            .clk_sys  (clk_sys),
            .sys_rst  (sys_rst),
            .activity (port_activity[p]),
            .env      (act_env[p])
        );
    end

    // Pattern selection
    assign wave0 = blink_wave[blink_pattern_zero];
    assign wave1 = (blink_pattern_one == sio_pkg::BP_BURST) ? burst_tog
                                                            : blink_wave[blink_pattern_one];

    // Per-pin output mode decode
    always_comb begin
        logic [2:0] src;
        logic       w;
        src = 3'h0;
        w = 1'b0;
        next_pin_out = '0;
        for (int p = 0; p < 32; p++) begin
            for (int b = 0; b < 4; b++) begin
                src = serial_output_config[p][3 * b +: 3];
                w = src[0] ? wave1 : wave0;
                case (src[2:1])
                    2'h0: next_pin_out[4 * p + b] = src[0];
                    2'h1: next_pin_out[4 * p + b] = w;
                    2'h2: next_pin_out[4 * p + b] = act_env[p] & w;
                    2'h3: next_pin_out[4 * p + b] = ~(act_env[p] & w);
                    default: next_pin_out[4 * p + b] = 1'b0;
                endcase
            end
        end
    end

    // Registered pin values for the shift engine; 128 pins in 32 ports
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pin_out <= '0;
        end else begin
            pin_out <= next_pin_out;
        end
    end

    // Read mux; unmapped and unaligned addresses read zero
    always_comb begin
        next_rdata = 32'h0;
        if (reg_rd && aligned) begin
            if (reg_addr == sio_pkg::ADDR_GEN) begin
                next_rdata[sio_pkg::GEN_BP0_LSB +: 2] = blink_pattern_zero;
                next_rdata[sio_pkg::GEN_BP1_LSB +: 2] = blink_pattern_one;
                next_rdata[sio_pkg::GEN_POS_LSB +: 4] = position_irq_enable;
            end else if (reg_addr == sio_pkg::ADDR_PIE) begin
                next_rdata = port_interrupt_enable;
            end else if (reg_addr[8:4] == sio_pkg::ADDR_POL[8:4]) begin
                next_rdata = pin_polarity[{reg_addr[3:2], 5'h00} +: 32];
            end else if (reg_addr[8:4] == sio_pkg::ADDR_STS[8:4]) begin
                next_rdata = sticky_irq_status[{reg_addr[3:2], 5'h00} +: 32];
            end else if (reg_addr[8:4] == sio_pkg::ADDR_IN[8:4]) begin
                next_rdata = input_data[{reg_addr[3:2], 5'h00} +: 32];
            end else if (reg_addr[8:7] == sio_pkg::ADDR_OCFG[8:7]) begin
                next_rdata = {20'h0, serial_output_config[reg_addr[6:2]]};
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_irq_follows: assert property (|(sticky_irq_status & irq_mask) |=> irq)
        else $error("interrupt not raised for enabled status");
    a_irq_quiet: assert property (!(|(sticky_irq_status & irq_mask)) |=> !irq)
        else $error("interrupt raised with no enabled status");
    a_sticky_sets: assert property (|pin_active |=> ((sticky_irq_status & $past(pin_active)) == $past(pin_active)))
        else $error("active input did not set status");
    a_sticky_keeps: assert property (!reg_wr |=> ((sticky_irq_status & $past(sticky_irq_status)) == $past(sticky_irq_status)))
        else $error("status bit dropped without a write");
    a_w1c_word: assert property ((reg_wr && reg_addr == sio_pkg::ADDR_STS) |=>
        ((sticky_irq_status[31:0] & $past(reg_wdata) & ~$past(pin_active[31:0])) == 32'h0))
        else $error("write one did not clear status");
    a_los_fwd: assert property (!gpio_los_sel[0] |=> los_out[0] == $past(pin_active[0]))
        else $error("loss of signal not forwarded");
    a_los_ignore: assert property (gpio_los_sel[0] |=> !los_out[0])
        else $error("serial LOS not ignored");
    a_static_one: assert property ((serial_output_config[0][2:0] == sio_pkg::SRC_STATIC1) |=> pin_out[0])
        else $error("static one not driven");
    a_act_off: assert property ((serial_output_config[0][8:6] == sio_pkg::SRC_ACT0 && !act_env[0]) |=> !pin_out[2])
        else $error("activity output on without envelope");
    a_read_pie: assert property ((reg_rd && reg_addr == sio_pkg::ADDR_PIE) |=> reg_rdata == $past(port_interrupt_enable))
        else $error("port enable read back wrong");

    c_irq_rise: cover property (!irq ##1 irq);
    c_irq_clear: cover property (irq ##1 !irq);
    c_los_fwd: cover property (los_out[0]);
    c_act_blink: cover property (act_env[0] && pin_out[0]);
endmodule

`default_nettype wire

// file: sio_chain_model.sv
// Model of the board shift register chain behind the serial pins
`default_nettype none

module sio_chain_model #(
    parameter int unsigned BURST_CYC = 12
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    // Burst request and controller side
    input  wire logic         go,
    input  wire logic [127:0] pin_out,
    output logic      [127:0] pin_in,
    output logic              pin_in_valid,
    output logic              burst_done,
    // Board side levels
    input  wire logic [127:0] board_in,
    output logic      [127:0] led
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned  cnt;
    logic [127:0] held;

    // Burst sequencing; a board level reaches the controller one burst after capture
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 0;
            held <= 128'h0;
            pin_in <= 128'h0;
            led <= 128'h0;
            pin_in_valid <= 1'b0;
            burst_done <= 1'b0;
        end else begin
            pin_in_valid <= 1'b0;
            burst_done <= 1'b0;
            pin_in <= ~pin_in;          // Lines carry nothing valid between bursts
            if (cnt == 0) begin
                if (go) begin
                    cnt <= BURST_CYC;
                end
            end else if (cnt == 1) begin
                cnt <= 0;
                led <= pin_out;         // Load strobe applies the shifted outputs
                held <= board_in;
                pin_in <= held;
                pin_in_valid <= 1'b1;
                burst_done <= 1'b1;
            end else begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule
`default_nettype wire

// file: sio_led_irq_test.sv
// Self-checking bench for the serial pin output, interrupt and loss-of-signal block
`default_nettype none

module sio_led_irq_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned HALF = 8;
    localparam int unsigned HOLD = 20;
    // Local loss-of-signal enables held by the port modules; only port 1 listens
    localparam logic [31:0] PORT_LOS_ENA = 32'h0000_0002;
    logic         clk_sys, sys_rst, reg_wr, reg_rd, pin_in_valid, burst_done, irq, go;
    logic [8:0]   reg_addr;
    logic [31:0]  reg_wdata, reg_rdata, port_activity, gpio_los_sel, los_out;
    logic [127:0] pin_in, pin_out, board_in;
    int           n_mismatch = 0;
    int           comparisons = 0;

    // Design and board chain
    sio_led_irq #(.BLINK_HALF_CYC(HALF), .ENV_HOLD_CYC(HOLD)) dut_u (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pin_in_valid(pin_in_valid), .burst_done(burst_done), .pin_out(pin_out),
        .port_activity(port_activity), .gpio_los_sel(gpio_los_sel), .los_out(los_out), .irq(irq));
    sio_chain_model chain_u (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .go(go), .pin_out(pin_out), .pin_in(pin_in),
        .pin_in_valid(pin_in_valid), .burst_done(burst_done), .board_in(board_in), .led());

    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic timed_out(input string what);
        n_mismatch++;
        $display("MISMATCH %s expected event seen timeout", what);
        wrap_up();
    endtask

    task automatic ticks(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input string what, input logic [8:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    endtask

    // One burst through the chain, bounded wait for its load
    task automatic burst();
        int n;
        n = 0;
        @(posedge clk_sys);
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        while (burst_done !== 1'b1) begin
            ticks(1);
            n++;
            if (n > 40) timed_out("burst");
        end
        ticks(2);                   // Let the toggle and the captured inputs reach the registered outputs
    endtask

    // Cycles until a pin changes
    task automatic edge_gap(input int p, output int n);
        logic v;
        v = pin_out[p];
        n = 0;
        while (pin_out[p] === v) begin
            ticks(1);
            n++;
            if (n > 600) timed_out("pin edge");
        end
    endtask

    task automatic per(input int p, input int exp);
        int n;
        ticks(2);
        edge_gap(p, n);
        edge_gap(p, n);
        chk("half period", exp, n);
    endtask

    task automatic t_reset();
        rd("general", sio_pkg::ADDR_GEN, 32'h0);
        rd("port enable", sio_pkg::ADDR_PIE, 32'h0);
        rd("output config", sio_pkg::ADDR_OCFG, 32'h0);
        rd("unmapped", 9'h1fc, 32'h0);
        chk("outputs", 32'h0, {irq, los_out[30:0]});
    endtask

    task automatic t_blink();
        int n;
        logic v;
        wr(sio_pkg::ADDR_OCFG, 32'h0000_001a);
        for (int k = 0; k < 4; k++) begin
            wr(sio_pkg::ADDR_GEN, 32'(k | (k << 2)));
            per(0, HALF << k);
            if (k < 3) per(1, HALF << k);
        end
        for (int i = 0; i < 2; i++) begin
            v = pin_out[1];
            burst();
            chk("burst toggle", {31'h0, ~v}, {31'h0, pin_out[1]});
        end
        wr(sio_pkg::ADDR_GEN, 32'h0000_001f);
        ticks(3);
        chk("cleared pins", 32'h0, {30'h0, pin_out[1:0]});
        edge_gap(0, n);
        chk("aligned phase", 32'h1, 32'((n >= HALF * 8 - 6) && (n <= HALF * 8 + 1)));
        rd("clear reads zero", sio_pkg::ADDR_GEN, 32'h0000_000f);
    endtask

    task automatic pulse_act(input logic [31:0] m);
        @(posedge clk_sys);
        port_activity <= m;
        @(posedge clk_sys);
        port_activity <= 32'h0;
    endtask

    task automatic act_len(input int gap);
        int n;
        pulse_act(32'h1);
        if (gap > 0) begin
            repeat (gap) @(posedge clk_sys);
            pulse_act(32'h1);
        end
        ticks(2);
        chk("active pins", 32'h1, {30'h0, pin_out[3:2]});
        n = 0;
        while (pin_out[2] === 1'b1 && n < 300) begin
            ticks(1);
            n++;
        end
        chk("envelope hold", 32'h1, 32'((n >= HOLD - 4) && (n <= HOLD + 1)));
        chk("idle pins", 32'h2, {30'h0, pin_out[3:2]});
    endtask

    task automatic t_act();
        wr(sio_pkg::ADDR_GEN, 32'h0000_001c);
        burst();
        wr(sio_pkg::ADDR_OCFG, 32'h0000_0f41);
        ticks(2);
        chk("idle port", 32'h9, {28'h0, pin_out[3:0]});
        pulse_act(32'h2);
        ticks(3);
        chk("other port", 32'h9, {28'h0, pin_out[3:0]});
        act_len(0);
        act_len(10);
        wr(sio_pkg::ADDR_OCFG, 32'h0000_0d01);
        ticks(2);
        chk("idle port", 32'h9, {28'h0, pin_out[3:0]});
    endtask

    task automatic t_irq();
        wr(sio_pkg::ADDR_GEN, 32'h0000_0200);
        wr(sio_pkg::ADDR_PIE, 32'h0000_0002);
        rd("port enable", sio_pkg::ADDR_PIE, 32'h0000_0002);
        board_in[5] <= 1'b1;
        burst();
        burst();
        ticks(3);
        chk("irq", 32'h1, {31'h0, irq});
        wr(sio_pkg::ADDR_STS, 32'h0000_0020);
        rd("status", sio_pkg::ADDR_STS, 32'h0000_0020);
        wr(sio_pkg::ADDR_GEN, 32'h0);
        ticks(3);
        chk("irq", 32'h0, {31'h0, irq});
        wr(sio_pkg::ADDR_GEN, 32'h0000_0200);
        board_in[5] <= 1'b0;
        burst();
        burst();
        ticks(2);
        chk("irq", 32'h1, {31'h0, irq});
        wr(sio_pkg::ADDR_STS, 32'h0000_0020);
        ticks(3);
        chk("irq", 32'h0, {31'h0, irq});
        wr(sio_pkg::ADDR_PIE, 32'h0000_0001);
        wr(sio_pkg::ADDR_POL, 32'h0000_0020);
        ticks(4);
        chk("irq", 32'h0, {31'h0, irq});
        rd("status", sio_pkg::ADDR_STS, 32'h0000_0020);
        wr(sio_pkg::ADDR_PIE, 32'h0000_0002);
        ticks(3);
        chk("irq", 32'h1, {31'h0, irq});
        wr(sio_pkg::ADDR_POL, 32'h0);
        wr(sio_pkg::ADDR_STS, 32'h0000_0020);
        ticks(3);
        chk("irq", 32'h0, {31'h0, irq});
    endtask

    task automatic t_los();
        board_in[4] <= 1'b1;
        burst();
        burst();
        ticks(2);
        chk("los", 32'h2, los_out);
        chk("los taken", 32'h2, los_out & PORT_LOS_ENA);
        gpio_los_sel <= 32'h2;
        ticks(2);
        chk("los", 32'h0, los_out);
        gpio_los_sel <= 32'h0;
        wr(sio_pkg::ADDR_POL, 32'h0000_0011);
        rd("polarity", sio_pkg::ADDR_POL, 32'h0000_0011);
        chk("los", 32'h1, los_out);
    endtask

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        reg_addr = 9'h000;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        go = 1'b0;
        port_activity = 32'h0;
        gpio_los_sel = 32'h0;
        board_in = 128'h0;
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_blink();
        t_act();
        t_irq();
        t_los();
        wrap_up();
    end
endmodule
`default_nettype wire
